// file: design/table_access_pkg.sv
package table_access_pkg;
  localparam int PTR_W = 16;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int FADDR_W = 8;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  // Default start of external program space (pointer at or above is external)
  localparam logic [15:0] EXT_BASE_DEF = 16'h1000;
  localparam logic [0:0] SEL_LOW = 1'h0;
  localparam logic [0:0] SEL_HIGH = 1'h1;

  typedef enum logic {
    OP_READ,
    OP_WRITE
  } table_op_e;

  typedef struct packed {
    table_op_e op;
    logic byte_sel;
    logic incr;
    logic [FADDR_W-1:0] faddr;
    logic [BYTE_W-1:0] fdata;
  } table_cmd_s;

  typedef struct packed {
    logic [PTR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } mem_req_s;
endpackage

// file: design/program_memory_table_access.sv
`timescale 1ns/10ps
// How it works
// RL1 - A table write copies register f into the low latch byte for select 0, high for 1.
// RL2 - After the byte load, the whole latch is written to the word at the pointer.
// RL3 - With increment set the pointer steps by one after the access, else it holds.
// RL4 - A write to external program memory completes in two instruction cycles.
// RL5 - A write to internal EPROM runs until an interrupt arrives, which ends it.
// RL6 - A table write is one word and takes two cycles, or many for on-chip EPROM.
// RL7 - Without programming voltage the internal write still runs but may fail.
// RL8 - A table read gives the selected latch byte to f, reloads the latch, may increment.
module program_memory_table_access
  import table_access_pkg::*;
#(
  parameter logic [15:0] EXT_BASE = EXT_BASE_DEF
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Instruction issue
  input wire logic cmd_valid_i,
  input wire table_access_pkg::table_cmd_s cmd_i,
  output logic busy_o,
  output logic done_o,
  // Register file write-back for table reads
  output logic f_we_o,
  output logic [table_access_pkg::FADDR_W-1:0] f_addr_o,
  output logic [table_access_pkg::BYTE_W-1:0] f_data_o,
  // Program memory port
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_ext_o,
  output logic eprom_prog_o,
  output table_access_pkg::mem_req_s mem_req_o,
  input wire logic [table_access_pkg::WORD_W-1:0] mem_rdata_i,
  // Interrupt and programming voltage sense
  input wire logic irq_i,
  input wire logic vpp_present_i,
  output logic prog_unsure_o
);
  import table_access_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_EPROM
  } st_e;

  st_e state_r;
  logic [PTR_W-1:0] table_pointer_r;
  logic [WORD_W-1:0] table_latch_r;
  logic incr_r;
  logic op_wr_r;
  logic irq_s1_r;
  logic irq_s2_r;
  logic vpp_s1_r;
  logic vpp_s2_r;
  logic ext_w;
  logic start_w;
  logic finish_w;
  logic eprom_start_w;

  function automatic logic is_external(input logic [PTR_W-1:0] p);
    return p >= EXT_BASE;
  endfunction

  // Latch with one byte replaced; the latch load and the write word must agree
  function automatic logic [WORD_W-1:0] merge_byte(
    input logic [WORD_W-1:0] cur,
    input logic sel,
    input logic [BYTE_W-1:0] b
  );
    return (sel == SEL_HIGH) ? {b, cur[BYTE_W-1:0]} : {cur[WORD_W-1:BYTE_W], b};
  endfunction

  assign ext_w = is_external(table_pointer_r);
  assign start_w = cmd_valid_i && state_r == ST_IDLE;
  assign eprom_start_w = start_w && cmd_i.op == OP_WRITE && !ext_w;
  // RL5 - interrupt ends EPROM write
  assign finish_w = state_r == ST_ACCESS || (state_r == ST_EPROM && irq_s2_r);

  // Pin-level inputs pass two flops first
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      irq_s1_r <= 1'h0;
      irq_s2_r <= 1'h0;
      vpp_s1_r <= 1'h0;
      vpp_s2_r <= 1'h0;
    end else begin
      irq_s1_r <= irq_i;
      irq_s2_r <= irq_s1_r;
      vpp_s1_r <= vpp_present_i;
      vpp_s2_r <= vpp_s1_r;
    end
  end

  // RL4 RL6 - cycle count per target
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      incr_r <= 1'h0;
      op_wr_r <= 1'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_w) begin
            incr_r <= cmd_i.incr;
            op_wr_r <= cmd_i.op == OP_WRITE;
            if (cmd_i.op == OP_WRITE && !ext_w) begin
              state_r <= ST_EPROM;
            end else begin
              state_r <= ST_ACCESS;
            end
          end
        end
        ST_ACCESS: begin
          state_r <= ST_IDLE;
        end
        ST_EPROM: begin
          if (irq_s2_r) begin
            state_r <= ST_IDLE;
          end
        end
        // The fourth code is unused; fall back to idle
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // RL1 RL8 - latch byte load and reload
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      table_latch_r <= LATCH_RST;
    end else if (start_w && cmd_i.op == OP_WRITE) begin
      table_latch_r <= merge_byte(table_latch_r, cmd_i.byte_sel, cmd_i.fdata);
    end else if (state_r == ST_ACCESS && !op_wr_r) begin
      table_latch_r <= mem_rdata_i;
    end
  end

  // RL3 - post-increment after access
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      table_pointer_r <= PTR_RST;
    end else if (finish_w && incr_r) begin
      table_pointer_r <= table_pointer_r + 16'h0001;
    end
  end

  // RL8 - selected byte to register f
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      f_we_o <= 1'h0;
      f_addr_o <= '0;
      f_data_o <= '0;
    end else begin
      f_we_o <= start_w && cmd_i.op == OP_READ;
      if (start_w) begin
        f_addr_o <= cmd_i.faddr;
        f_data_o <= (cmd_i.byte_sel == SEL_HIGH) ? table_latch_r[15:8] : table_latch_r[7:0];
      end
    end
  end

  // RL4 - one-cycle memory strobes
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mem_rd_o <= 1'h0;
      mem_wr_o <= 1'h0;
      mem_ext_o <= 1'h0;
    end else begin
      mem_rd_o <= start_w && cmd_i.op == OP_READ;
      mem_wr_o <= start_w && cmd_i.op == OP_WRITE && ext_w;
      mem_ext_o <= start_w ? ext_w : (state_r == ST_ACCESS ? 1'h0 : mem_ext_o);
    end
  end

  // RL5 - programming until interrupt
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      eprom_prog_o <= 1'h0;
    end else if (eprom_start_w) begin
      eprom_prog_o <= 1'h1;
    end else if (state_r == ST_EPROM && irq_s2_r) begin
      eprom_prog_o <= 1'h0;
    end
  end

  // RL7 - doubtful program flag
  // Programming is never gated on the supply; the flag only tells software
  // Sticky until the next programming start, and a set beats that clear
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prog_unsure_o <= 1'h0;
    end else if (eprom_prog_o && !vpp_s2_r) begin
      prog_unsure_o <= 1'h1;
    end else if (eprom_start_w) begin
      prog_unsure_o <= 1'h0;
    end
  end

  // RL2 - whole latch to word
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mem_req_o <= '0;
    end else if (start_w) begin
      mem_req_o.addr <= table_pointer_r;
      if (cmd_i.op == OP_WRITE) begin
        mem_req_o.data <= merge_byte(table_latch_r, cmd_i.byte_sel, cmd_i.fdata);
      end else begin
        mem_req_o.data <= table_latch_r;
      end
    end
  end

  // RL6 - busy and completion
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      busy_o <= 1'h0;
      done_o <= 1'h0;
    end else begin
      busy_o <= start_w || (state_r != ST_IDLE && !finish_w);
      done_o <= finish_w;
    end
  end
endmodule

// file: dv/table_access_props.sv
`timescale 1ns/10ps
module table_access_props
  import table_access_pkg::*;
(
  // Watched ports
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire table_access_pkg::table_cmd_s cmd_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic f_we_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic mem_ext_o,
  input wire logic eprom_prog_o,
  input wire table_access_pkg::mem_req_s mem_req_o,
  input wire logic irq_i,
  input wire logic prog_unsure_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_take; cmd_valid_i && !busy_o && !done_o |=> busy_o; endproperty
  a_take: assert property (p_take) else $error("take not busy");
  property p_wr; mem_wr_o |=> done_o && !busy_o; endproperty
  a_wr: assert property (p_wr) else $error("ext write late");
  property p_ext; mem_wr_o |-> mem_ext_o && busy_o && !eprom_prog_o; endproperty
  a_ext: assert property (p_ext) else $error("write target wrong");
  property p_rd; mem_rd_o |-> f_we_o ##1 done_o; endproperty
  a_rd: assert property (p_rd) else $error("read sequence wrong");
  property p_lo; cmd_valid_i && !busy_o && !done_o && cmd_i.op == OP_WRITE && !cmd_i.byte_sel
    |=> mem_req_o.data[7:0] == $past(cmd_i.fdata); endproperty
  a_lo: assert property (p_lo) else $error("low byte wrong");
  property p_irq; $rose(irq_i) && eprom_prog_o |-> ##[1:5] done_o; endproperty
  a_irq: assert property (p_irq) else $error("irq did not end write");
  property p_ep; eprom_prog_o && !done_o |-> busy_o; endproperty
  a_ep: assert property (p_ep) else $error("programming while idle");
  property p_un; prog_unsure_o && !busy_o && !cmd_valid_i |=> prog_unsure_o; endproperty
  a_un: assert property (p_un) else $error("unsure flag lost");
endmodule
bind program_memory_table_access table_access_props i_table_access_props(.*);

// file: dv/prog_mem_model.sv
`timescale 1ns/10ps
module prog_mem_model
  import table_access_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire table_access_pkg::mem_req_s req_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem_r [16];
  logic [15:0] last_r = 16'h0000;
  initial for (int a = 0; a < 16; a++) mem_r[a] = {a[7:0] ^ 8'h5A, ~a[7:0]};
  // Released bus shows the inverse of the last word, never a stale match
  assign rdata_o = mem_rd_i ? mem_r[req_i.addr[3:0]] : ~last_r;
  always @(posedge ref_clk_i) begin
    if (mem_rd_i) last_r <= rdata_o;
    if (mem_wr_i) mem_r[req_i.addr[3:0]] <= req_i.data;
  end
endmodule

// file: dv/test_program_memory_table_access.sv
`timescale 1ns/10ps
module test_program_memory_table_access import table_access_pkg::*;;
  logic ref_clk_i = 0, sys_rst_i = 1, cmd_valid_i = 0, irq_i = 0, vpp_present_i = 1, ep_d = 0;
  table_cmd_s cmd_i = '0;
  logic busy_o, done_o, f_we_o, mem_rd_o, mem_wr_o, mem_ext_o, eprom_prog_o, prog_unsure_o;
  logic [7:0] f_addr_o, f_data_o;
  logic [15:0] mem_rdata_i, ptr = 0, lat = 0;
  mem_req_s mem_req_o;
  logic [31:0] q[$];
  int err_count = 0, checks_done = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  program_memory_table_access #(.EXT_BASE(16'h0002)) i_program_memory_table_access(.*);
  prog_mem_model i_prog_mem_model(.ref_clk_i, .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .req_i(mem_req_o), .rdata_o(mem_rdata_i));
  task chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task op(input logic w, s, i, input logic [7:0] d);
    logic [7:0] fa;
    logic ex;
    logic ep;
    int n;
    fa = 8'($urandom);
    ex = ptr >= 16'h0002;
    ep = w && !ex;
    if (ep) begin
      // Supply sense passes two flops, so let it settle before the issue
      vpp_present_i = !vpp_present_i;
      repeat (2) @(negedge ref_clk_i);
    end
    cmd_i = '{table_op_e'(w), s, i, fa, d};
    cmd_valid_i = 1;
    if (w) begin
      if (s) lat[15:8] = d;
      else lat[7:0] = d;
      q.push_back({ptr, lat});
    end else begin
      q.push_back({16'h0, fa, s ? lat[15:8] : lat[7:0]});
      lat = {ptr[7:0] ^ 8'h5A, ~ptr[7:0]};
    end
    ptr = ptr + 16'(i);
    @(negedge ref_clk_i) cmd_valid_i = 0;
    chk(busy_o, 1);
    chk(mem_ext_o, ex);
    if (ep) begin
      repeat (6) @(negedge ref_clk_i);
      irq_i = 1;
    end
    for (n = 0; n < 9 && done_o !== 1; n++) @(negedge ref_clk_i);
    chk(done_o, 1);
    if (!ep) chk(n, 1);
    irq_i = 0;
    if (ep) chk(prog_unsure_o, !vpp_present_i);
    @(negedge ref_clk_i);
  endtask
  always @(negedge ref_clk_i) begin
    ep_d <= eprom_prog_o;
    if (mem_wr_o || (eprom_prog_o && !ep_d)) chk(mem_req_o, q.pop_front());
    if (f_we_o) chk({16'h0, f_addr_o, f_data_o}, q.pop_front());
  end
  initial begin
    #20us;
    err_count++;
    test_done;
  end
  initial begin
    void'($urandom(49));
    repeat (4) @(negedge ref_clk_i);
    sys_rst_i = 0;
    @(negedge ref_clk_i);
    op(1, 0, 0, 8'($urandom));
    op(1, 1, 1, 8'($urandom));
    op(0, 1, 1, 8'h00);
    op(0, 0, 0, 8'h00);
    for (int k = 0; k < 12; k++) op(1, k[0], 1'($urandom), 8'($urandom));
    test_done;
  end
endmodule
